// File: include/periodic_microframe_writeback_regs.svh
`ifndef PERIODIC_MICROFRAME_WRITEBACK_REGS_SVH
`define PERIODIC_MICROFRAME_WRITEBACK_REGS_SVH

// Register byte offsets
`define PMW_OFF_WORD_TWO      8'h00
`define PMW_OFF_WORD_FOUR     8'h04
`define PMW_OFF_WORD_FIVE_LO  8'h08
`define PMW_OFF_WORD_FIVE_HI  8'h0c
`define PMW_OFF_WORD_SIX_LO   8'h10
`define PMW_OFF_WORD_SIX_HI   8'h14
`define PMW_OFF_IRQ_STATUS    8'h18
`define PMW_OFF_IRQ_MASK      8'h1c

// Field positions
`define PMW_FRAME_LSB         3
`define PMW_FRAME_MSB         7
`define PMW_MASK_LSB          0
`define PMW_STATUS_LSB        8
`define PMW_STATUS_W          3
`define PMW_COUNT_W           12
`define PMW_CNT0_LSB          32
`define PMW_CNT1_LSB          44
`define PMW_CNT2_LO_LSB       56
`define PMW_CNT2_HI_LSB       0
`define PMW_CNT3_LSB          4
`define PMW_CNT4_LSB          16
`define PMW_CNT5_LSB          28
`define PMW_CNT6_LSB          40
`define PMW_CNT7_LSB          52

// Completion code bits
`define PMW_CC_XACT_ERR       0
`define PMW_CC_BABBLE         1
`define PMW_CC_UNDERRUN       2

// Interrupt status bits
`define PMW_IRQ_MF_DONE       0
`define PMW_IRQ_MF_ERROR      1
`define PMW_IRQ_FRAME_DONE    2

// Reset values
`define PMW_RST_WORD32        32'h0000_0000
`define PMW_RST_WORD64        64'h0000_0000_0000_0000
`define PMW_RST_IRQ           3'h0

`endif

// File: include/pmw_pkg.sv
package pmw_pkg;

	typedef enum logic [1:0] {
		PMW_IDLE = 2'b01,
		PMW_WAIT = 2'b10
	} pmw_state_e;

	typedef struct packed {
		logic        req;
		logic [7:0]  addr;
		logic        wr;
		logic [31:0] wdata;
	} pmw_bus_s;

	typedef struct packed {
		logic        done;
		logic        is_in;
		logic        xact_err;
		logic        babble;
		logic        underrun;
		logic [11:0] count;
	} pmw_result_s;

	typedef struct packed {
		logic       start;
		logic [4:0] frame;
		logic [2:0] index;
	} pmw_uframe_s;

endpackage : pmw_pkg

// File: src/pmw_writeback.sv
// The implementer's own choices: the strobed register port and the register addresses.
`include "periodic_microframe_writeback_regs.svh"

module pmw_writeback
(
	// Clock and reset
	input  wire logic                mclk,
	input  wire logic                rst_n,
	// Register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [31:0]         reg_rdata,
	// Microframe timing from the bus side
	input  wire pmw_pkg::pmw_uframe_s uframe_in,
	// Transaction request and outcome
	output logic                     txn_req,
	output logic      [2:0]          txn_index,
	input  wire pmw_pkg::pmw_result_s txn_result,
	// Interrupt
	output logic                     irq
);
	import pmw_pkg::*;

	pmw_state_e  state_reg;
	logic [31:0] word_two_reg;
	logic [31:0] word_four_reg;
	logic [63:0] word_five_reg;
	logic [63:0] word_six_reg;
	logic [2:0]  irq_status_reg;
	logic [2:0]  irq_mask_reg;
	logic [2:0]  cur_index_reg;
	logic [7:0]  mf_mask;
	logic        frame_match;
	logic        launch;
	logic        finish;
	logic [2:0]  code;
	logic [2:0]  irq_set;
	// Next-state values
	logic [31:0] word_two_next;
	logic [31:0] word_four_next;
	logic [63:0] word_five_next;
	logic [63:0] word_six_next;
	logic [63:0] five_sw;
	logic [63:0] six_sw;
	logic [2:0]  irq_status_next;
	logic [31:0] rdata_next;

	// Place a 12-bit count into the two count words
	function automatic logic [127:0] put_count(input logic [63:0] w5, input logic [63:0] w6,
		input logic [2:0] idx, input logic [11:0] cnt);
		logic [63:0] a;
		logic [63:0] b;
		a = w5;
		b = w6;
		case (idx)
			// Counts 0 and 1 sit in word five
			3'h0:
			begin
				a[`PMW_CNT0_LSB +: `PMW_COUNT_W] = cnt;
			end
			3'h1:
			begin
				a[`PMW_CNT1_LSB +: `PMW_COUNT_W] = cnt;
			end
			// Count 2 straddles both words
			3'h2:
			begin
				a[`PMW_CNT2_LO_LSB +: 8] = cnt[7:0];
				b[`PMW_CNT2_HI_LSB +: 4] = cnt[11:8];
			end
			// Counts 3 to 7 sit in word six
			3'h3:
			begin
				b[`PMW_CNT3_LSB +: `PMW_COUNT_W] = cnt;
			end
			3'h4:
			begin
				b[`PMW_CNT4_LSB +: `PMW_COUNT_W] = cnt;
			end
			3'h5:
			begin
				b[`PMW_CNT5_LSB +: `PMW_COUNT_W] = cnt;
			end
			3'h6:
			begin
				b[`PMW_CNT6_LSB +: `PMW_COUNT_W] = cnt;
			end
			default:
			begin
				b[`PMW_CNT7_LSB +: `PMW_COUNT_W] = cnt;
			end
		endcase
		put_count = {a, b};
	endfunction : put_count

	// Byte address compare used by the decoder
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction : hit

	// Mask and frame compare gate every microframe start
	assign mf_mask     = word_four_reg[`PMW_MASK_LSB +: 8];
	assign frame_match = (uframe_in.frame == word_two_reg[`PMW_FRAME_MSB:`PMW_FRAME_LSB]);
	assign launch      = (state_reg == PMW_IDLE) && uframe_in.start && frame_match
		&& mf_mask[uframe_in.index];
	assign finish      = (state_reg == PMW_WAIT) && txn_result.done;

	// Completion code of the finished transaction
	always_comb
	begin
		code = 3'h0;
		code[`PMW_CC_XACT_ERR] = txn_result.xact_err;
		code[`PMW_CC_BABBLE]   = txn_result.babble && txn_result.is_in;
		code[`PMW_CC_UNDERRUN] = txn_result.underrun && !txn_result.is_in;
	end

	// Interrupt events of the finished microframe
	always_comb
	begin
		irq_set = 3'h0;
		irq_set[`PMW_IRQ_MF_DONE]    = finish;
		irq_set[`PMW_IRQ_MF_ERROR]   = finish && (code != 3'h0);
		irq_set[`PMW_IRQ_FRAME_DONE] = finish && (cur_index_reg == 3'h7);
	end

	// Transaction sequencer; one transaction outstanding, later starts are dropped
	// Done is honoured only while waiting
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			state_reg <= PMW_IDLE;
		else
		begin
			case (state_reg)
				PMW_IDLE:
				begin
					if (launch)
						state_reg <= PMW_WAIT;
				end
				PMW_WAIT:
				begin
					if (txn_result.done)
						state_reg <= PMW_IDLE;
				end
				default:
				begin
					state_reg <= PMW_IDLE;
				end
			endcase
		end
	end

	// Microframe being served, kept for the write-back
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			cur_index_reg <= 3'h0;
		else if (launch)
			cur_index_reg <= uframe_in.index;
	end

	// One-cycle request pulse
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			txn_req <= 1'b0;
		else
			txn_req <= launch;
	end

	// Request index, held until the next request
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			txn_index <= 3'h0;
		else if (launch)
			txn_index <= uframe_in.index;
	end

	// Software view of the count words before any write-back
	always_comb
	begin
		five_sw = word_five_reg;
		six_sw  = word_six_reg;
		if (reg_wr)
		begin
			if (hit(reg_addr, `PMW_OFF_WORD_FIVE_LO))
				five_sw[31:0] = reg_wdata;
			else if (hit(reg_addr, `PMW_OFF_WORD_FIVE_HI))
				five_sw[63:32] = reg_wdata;
			else if (hit(reg_addr, `PMW_OFF_WORD_SIX_LO))
				six_sw[31:0] = reg_wdata;
			else if (hit(reg_addr, `PMW_OFF_WORD_SIX_HI))
				six_sw[63:32] = reg_wdata;
		end
	end

	// Write-back replaces only the count field it owns
	// A software write in the same cycle keeps every other bit it carries
	always_comb
	begin
		word_five_next = five_sw;
		word_six_next  = six_sw;
		if (finish)
			{word_five_next, word_six_next} = put_count(five_sw, six_sw, cur_index_reg,
				txn_result.count);
	end

	// Word four: software write first, then the finished microframe's code
	// Mask bits are never cleared by hardware
	always_comb
	begin
		word_four_next = word_four_reg;
		if (reg_wr && hit(reg_addr, `PMW_OFF_WORD_FOUR))
			word_four_next = reg_wdata;
		if (finish)
			word_four_next[`PMW_STATUS_LSB + `PMW_STATUS_W * cur_index_reg +: `PMW_STATUS_W]
				= code;
	end

	// Word two carries the descriptor frame number
	always_comb
	begin
		word_two_next = word_two_reg;
		if (reg_wr && hit(reg_addr, `PMW_OFF_WORD_TWO))
			word_two_next = reg_wdata;
	end

	// Write one to clear; a set in the same cycle wins
	always_comb
	begin
		irq_status_next = irq_status_reg;
		if (reg_wr && hit(reg_addr, `PMW_OFF_IRQ_STATUS))
			irq_status_next = irq_status_reg & ~reg_wdata[2:0];
		irq_status_next = irq_status_next | irq_set;
	end

	// Read selection; idle cycles and unmapped addresses read as zero
	always_comb
	begin
		rdata_next = 32'h0;
		if (reg_rd)
		begin
			if (hit(reg_addr, `PMW_OFF_WORD_TWO))
				rdata_next = word_two_reg;
			else if (hit(reg_addr, `PMW_OFF_WORD_FOUR))
				rdata_next = word_four_reg;
			else if (hit(reg_addr, `PMW_OFF_WORD_FIVE_LO))
				rdata_next = word_five_reg[31:0];
			else if (hit(reg_addr, `PMW_OFF_WORD_FIVE_HI))
				rdata_next = word_five_reg[63:32];
			else if (hit(reg_addr, `PMW_OFF_WORD_SIX_LO))
				rdata_next = word_six_reg[31:0];
			else if (hit(reg_addr, `PMW_OFF_WORD_SIX_HI))
				rdata_next = word_six_reg[63:32];
			else if (hit(reg_addr, `PMW_OFF_IRQ_STATUS))
				rdata_next = {29'h0, irq_status_reg};
			else if (hit(reg_addr, `PMW_OFF_IRQ_MASK))
				rdata_next = {29'h0, irq_mask_reg};
		end
	end

	// Descriptor words
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			word_two_reg <= `PMW_RST_WORD32;
		else
			word_two_reg <= word_two_next;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			word_four_reg <= `PMW_RST_WORD32;
		else
			word_four_reg <= word_four_next;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			word_five_reg <= `PMW_RST_WORD64;
		else
			word_five_reg <= word_five_next;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			word_six_reg <= `PMW_RST_WORD64;
		else
			word_six_reg <= word_six_next;
	end

	// Interrupt status, sticky until software writes ones
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq_status_reg <= `PMW_RST_IRQ;
		else
			irq_status_reg <= irq_status_next;
	end

	// Interrupt mask, software only
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq_mask_reg <= `PMW_RST_IRQ;
		else if (reg_wr && hit(reg_addr, `PMW_OFF_IRQ_MASK))
			irq_mask_reg <= reg_wdata[2:0];
	end

	// Level interrupt, one cycle behind status and mask
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(irq_status_reg & irq_mask_reg);
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
			reg_rdata <= `PMW_RST_WORD32;
		else
			reg_rdata <= rdata_next;
	end

endmodule : pmw_writeback

// File: test/pmw_writeback_props.sv
module pmw_writeback_props
(
	// Clock and reset
	input wire logic                 mclk,
	input wire logic                 rst_n,
	// Watched ports
	input wire logic                 reg_wr,
	input wire logic                 reg_rd,
	input wire logic [31:0]          reg_rdata,
	input wire pmw_pkg::pmw_uframe_s uframe_in,
	input wire logic                 txn_req,
	input wire logic [2:0]           txn_index,
	input wire pmw_pkg::pmw_result_s txn_result,
	input wire logic                 irq
);
	timeunit 1ns;
	timeprecision 1ns;
	import pmw_pkg::*;
	default clocking dc @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_req_start: assert property (txn_req |-> $past(uframe_in.start))
		else $error("request without start");
	a_req_index: assert property (txn_req |-> txn_index == $past(uframe_in.index))
		else $error("wrong index");
	a_req_pulse: assert property (txn_req |=> !txn_req)
		else $error("long request");
	a_index_hold: assert property ($past(rst_n) && !txn_req |-> $stable(txn_index))
		else $error("index moved");
	a_one_out: assert property (txn_req |=> !txn_req until txn_result.done)
		else $error("second request");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("stray read data");
	a_irq_rise: assert property ($rose(irq) |-> $past(txn_result.done, 2) || $past(reg_wr, 2))
		else $error("irq without cause");
	a_irq_fall: assert property ($fell(irq) |-> $past(reg_wr, 2) || !$past(rst_n))
		else $error("irq dropped");
endmodule : pmw_writeback_props

bind pmw_writeback pmw_writeback_props pmw_writeback_props_inst (.mclk, .rst_n, .reg_wr, .reg_rd,
	.reg_rdata, .uframe_in, .txn_req, .txn_index, .txn_result, .irq);

// File: test/pmw_usb_dev.sv
module pmw_usb_dev
(
	// Clock
	input  wire logic                 mclk,
	// Request and answer
	input  wire logic                 txn_req,
	input  wire pmw_pkg::pmw_result_s rsp,
	input  wire logic [3:0]           lat,
	output pmw_pkg::pmw_result_s      txn_result
);
	timeunit 1ns;
	timeprecision 1ns;
	import pmw_pkg::*;
	logic [3:0] cnt_reg;
	initial
	begin
		cnt_reg = 4'h0;
		txn_result = '0;
	end
	// Answer after lat cycles; outside the answer the flags are scrambled
	always @(posedge mclk)
	begin
		cnt_reg <= txn_req ? lat : cnt_reg - 4'(cnt_reg != 4'h0);
		txn_result <= cnt_reg == 4'h1 ? {1'b1, rsp[15:0]} : {1'b0, ~rsp[15:0]};
	end
endmodule : pmw_usb_dev

// File: test/pmw_writeback_tb.sv
module pmw_writeback_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import pmw_pkg::*;
	logic        mclk, rst_n, reg_wr, reg_rd, txn_req, irq;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, w2, w4, st, im;
	logic [2:0]  txn_index, code;
	logic [3:0]  lat;
	logic [63:0] w5, w6;
	pmw_uframe_s uframe_in;
	pmw_result_s txn_result, rsp;
	int          err_total, cmp_count, n;
	pmw_writeback pmw_writeback_inst (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .uframe_in, .txn_req, .txn_index, .txn_result, .irq);
	pmw_usb_dev pmw_usb_dev_inst (.mclk, .txn_req, .rsp, .lat, .txn_result);
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 if (!w) chk(reg_rdata, d);
	endtask : bus
	task automatic finish_test;
		if (err_total == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	task automatic mf(input int i, input logic [4:0] f);
		rsp <= 17'($urandom);
		lat <= 4'($urandom_range(1, 9));
		@(posedge mclk);
		uframe_in <= {1'b1, f, 3'(i)};
		@(posedge mclk);
		uframe_in.start <= 1'b0;
		#1 chk(32'(txn_req), 32'(w4[i] && f == w2[7:3]));
		if (txn_req !== 1'b1)
			return;
		chk(32'(txn_index), i);
		for (n = 0; txn_result.done !== 1'b1 && n < 30; n++)
			@(posedge mclk) #1;
		chk(32'(txn_result.done), 1);
		code = {!rsp.is_in & rsp.underrun, rsp.is_in & rsp.babble, rsp.xact_err};
		w4[8 + 3 * i +: 3] = code;
		if (i < 2)
			w5[32 + 12 * i +: 12] = rsp.count;
		else if (i == 2)
			{w6[3:0], w5[63:56]} = rsp.count;
		else
			w6[4 + 12 * (i - 3) +: 12] = rsp.count;
		st = {29'h0, i == 7, code != 3'h0, 1'b1};
		bus(0, 8'h04, w4);
		bus(0, 8'h08, w5[31:0]);
		bus(0, 8'h0c, w5[63:32]);
		bus(0, 8'h10, w6[31:0]);
		bus(0, 8'h14, w6[63:32]);
		bus(0, 8'h18, st);
		chk(32'(irq), 32'(|(st[2:0] & im[2:0])));
		bus(1, 8'h18, 32'h7);
		@(posedge mclk) #1 chk(32'(irq), 0);
	endtask : mf
	initial
	begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, uframe_in, rsp, lat} = '0;
		{w2, w4, w5, w6, im, err_total, cmp_count} = '0;
		void'($urandom(39));
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		bus(0, 8'h20, 32'h0);
		for (int r = 0; r < 12; r++)
		begin
			w2 = $urandom;
			w4[7:0] = 8'($urandom);
			im = $urandom;
			bus(1, 8'h00, w2);
			bus(1, 8'h04, w4);
			bus(1, 8'h1c, im);
			bus(0, 8'h00, w2);
			bus(0, 8'h1c, {29'h0, im[2:0]});
			for (int i = 0; i < 8; i++)
				mf(i, r % 3 == 0 ? ~w2[7:3] : w2[7:3]);
		end
		finish_test();
	end
	initial
	begin
		#400000;
		err_total++;
		finish_test();
	end
endmodule : pmw_writeback_tb
